// ### core/wdt_pkg.sv
package wdt_pkg;
    // register index on the plain register port
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CLK_SEL = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h5;

    // control/status one field positions
    localparam int ONE_COUNTER_WE_INH = 7;
    localparam int ONE_COUNTER_WE = 6;
    localparam int ONE_CONTROL_WE_INH = 5;
    localparam int ONE_CONTROL_WE = 4;
    localparam int ONE_RUN_INH = 3;
    localparam int ONE_RUN = 2;
    localparam int ONE_RST_FLAG_INH = 1;
    localparam int ONE_RST_FLAG = 0;
    localparam logic [7:0] ONE_READ_ONES = 8'haa;

    // control/status two field positions
    localparam int TWO_OVF = 7;
    localparam int TWO_MODE_INH = 6;
    localparam int TWO_MODE = 5;
    localparam int TWO_IRQ_EN_INH = 4;
    localparam int TWO_IRQ_EN = 3;
    localparam logic [7:0] TWO_READ_ONES = 8'h57;

    // counter and clock select
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] COUNTER_MAX = 8'hff;
    localparam logic [3:0] CLK_SEL_RESET = 4'hf;
    localparam logic [7:0] CLK_SEL_READ_ONES = 8'hf0;
    localparam int CLK_SEL_SYS_BIT = 3;

    // prescaler: system division starts at 1/64, oscillator path is 1/2048
    localparam int SYS_DIV_BASE_LOG2 = 6;
    localparam int SYS_DIV_W = 13;
    localparam int OSC_DIV_W = 11;

    // sticky interrupt status layout
    localparam int IRQ_W = 2;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_WDRST = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
endpackage

// ### core/wdt_prescaler.sv
`timescale 1ns/1ps
module wdt_prescaler
    import wdt_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // control
    input wire logic i_enable,
    input wire logic i_osc_tick,
    input wire logic [3:0] i_clk_sel,
    // counter clock pulse
    output logic o_tick
);

    logic [SYS_DIV_W-1:0] sys_div_reg;
    logic [SYS_DIV_W-1:0] sys_div_next;
    logic [OSC_DIV_W-1:0] osc_div_reg;
    logic [OSC_DIV_W-1:0] osc_div_next;
    logic tick_reg;
    logic tick_next;

    // low-bit mask for division 2^(6+sel)
    function automatic logic [SYS_DIV_W-1:0] div_mask(input logic [2:0] sel);
        div_mask = ~({SYS_DIV_W{1'b1}} << (SYS_DIV_BASE_LOG2 + 32'(sel)));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // dividers restart when halted so the first period after start is whole
    always_comb begin
        sys_div_next = '0;
        osc_div_next = '0;
        tick_next = 1'b0;
        if (i_enable) begin
            sys_div_next = sys_div_reg + 13'h0001;
            osc_div_next = osc_div_reg;
            if (i_clk_sel[CLK_SEL_SYS_BIT]) begin
                // codes 1000..1111 give 1/64 .. 1/8192, see RULE_03, see RULE_19
                tick_next = (sys_div_reg & div_mask(i_clk_sel[2:0])) == div_mask(i_clk_sel[2:0]);
            end else if (i_osc_tick) begin
                // oscillator divided by 2048, see RULE_03
                osc_div_next = osc_div_reg + 11'h001;
                tick_next = &osc_div_reg;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sys_div_reg <= '0;
            osc_div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            sys_div_reg <= sys_div_next;
            osc_div_reg <= osc_div_next;
            tick_reg <= tick_next;
        end
    end

    assign o_tick = tick_reg;

endmodule

// ### core/watchdog_interval_timer_ctrl.sv
// Behaviour
// RULE_01 - eight-bit counter; overflow in watchdog mode issues an internal reset
// RULE_02 - in interval mode every overflow raises the interval interrupt instead
// RULE_03 - nine clock sources: system 1/64 to 1/8192, or oscillator 1/2048
// RULE_04 - counter write enable changes only when bit 7 is written zero
// RULE_05 - counter accepts software writes only while counter write enable is one
// RULE_06 - control write enable changes only when bit 5 is written zero
// RULE_07 - run bit and reset flag writable only while control write enable is one
// RULE_08 - inhibit bits 7, 5, 3 and 1 always read as one
// RULE_09 - counter runs while run bit is one; set by guarded write of one
// RULE_10 - run bit cleared by pin reset or guarded write of zero
// RULE_11 - reset flag set when overflow produces the internal reset
// RULE_12 - reset flag cleared by pin reset or guarded write of zero
// RULE_13 - software writes the first control register with whole-byte writes only
// RULE_14 - software stops the counter before watch or standby on system clock
// RULE_15 - module standby input stops the timer independently
// RULE_16 - up-counter resets to zero; wrap sets overflow flag and watchdog flag (code sets the reset flag only on wraps in watchdog mode)
// RULE_17 - mode select zero is watchdog, one is interval timer
// RULE_18 - overflow flag clears on read-as-one then write zero; enable gates irq
// RULE_19 - clock select code 1000 is 1/64, doubling per code to 1111
`timescale 1ns/1ps
module watchdog_interval_timer_ctrl
    import wdt_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // oscillator clock pin and standby
    input wire logic i_osc_clk,
    input wire logic i_module_standby,
    // events out
    output logic o_wdt_reset,
    output logic o_interval_irq,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic counter_we_reg, counter_we_next;
    logic control_we_reg, control_we_next;
    logic run_bit_reg, run_bit_next;
    logic reset_flag_reg, reset_flag_next;
    logic overflow_flag_reg, overflow_flag_next;
    logic ovf_armed_reg, ovf_armed_next;
    logic mode_select_reg, mode_select_next;
    logic irq_enable_reg, irq_enable_next;
    logic [7:0] counter_reg, counter_next;
    logic [3:0] clk_sel_reg, clk_sel_next;
    logic [IRQ_W-1:0] irq_status_reg, irq_status_next;
    logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic wdt_reset_reg, wdt_reset_next;
    logic interval_irq_reg, interval_irq_next;
    logic irq_reg, irq_next;
    logic osc_meta_reg, osc_s2_reg, osc_s3_reg;
    logic osc_level_reg, osc_level_next;
    logic osc_tick_reg, osc_tick_next;
    logic tick;
    logic wr_one, wr_two, wr_cnt;
    logic cnt_accept, ovf_event, wdrst_event;

    ////////////////////////////////////////////////////////////////////////
    // oscillator pin: three flops, a rising change counts once s2 and s3 agree
    always_comb begin
        osc_level_next = osc_level_reg;
        osc_tick_next = 1'b0;
        if (osc_s2_reg == osc_s3_reg) begin
            osc_level_next = osc_s3_reg;
            osc_tick_next = osc_s3_reg & ~osc_level_reg;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_meta_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
            osc_level_reg <= 1'b0;
            osc_tick_reg <= 1'b0;
        end else begin
            osc_meta_reg <= i_osc_clk;
            osc_s2_reg <= osc_meta_reg;
            osc_s3_reg <= osc_s2_reg;
            osc_level_reg <= osc_level_next;
            osc_tick_reg <= osc_tick_next;
        end
    end

    // standby halts the prescaler too, see RULE_15
    wdt_prescaler u_prescaler (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_enable(run_bit_reg & ~i_module_standby),
        .i_osc_tick(osc_tick_reg),
        .i_clk_sel(clk_sel_reg),
        .o_tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode and counter events
    assign wr_one = i_wr && (i_addr == ADDR_CTRL_ONE);
    assign wr_two = i_wr && (i_addr == ADDR_CTRL_TWO);
    assign wr_cnt = i_wr && (i_addr == ADDR_COUNTER);
    assign cnt_accept = wr_cnt && counter_we_reg; // see RULE_05
    // a software rewrite in the same cycle beats the wrap
    assign ovf_event = tick && run_bit_reg && !i_module_standby && !cnt_accept
        && (counter_reg == COUNTER_MAX); // see RULE_16
    assign wdrst_event = ovf_event && !mode_select_reg; // see RULE_01, see RULE_17

    ////////////////////////////////////////////////////////////////////////
    // register file next values
    always_comb begin
        counter_we_next = counter_we_reg;
        control_we_next = control_we_reg;
        run_bit_next = run_bit_reg;
        reset_flag_next = reset_flag_reg;
        overflow_flag_next = overflow_flag_reg;
        ovf_armed_next = ovf_armed_reg;
        mode_select_next = mode_select_reg;
        irq_enable_next = irq_enable_reg;
        counter_next = counter_reg;
        clk_sel_next = clk_sel_reg;
        irq_status_next = irq_status_reg;
        irq_mask_next = irq_mask_reg;
        // control one: each field needs its inhibit bit written zero
        if (wr_one) begin
            if (!i_wdata[ONE_COUNTER_WE_INH]) begin
                counter_we_next = i_wdata[ONE_COUNTER_WE]; // see RULE_04
            end
            if (!i_wdata[ONE_CONTROL_WE_INH]) begin
                control_we_next = i_wdata[ONE_CONTROL_WE]; // see RULE_06
            end
            // guard uses the enable held before this write
            if (control_we_reg && !i_wdata[ONE_RUN_INH]) begin
                run_bit_next = i_wdata[ONE_RUN]; // see RULE_07, see RULE_09, see RULE_10
            end
            if (control_we_reg && !i_wdata[ONE_RST_FLAG_INH] && !i_wdata[ONE_RST_FLAG]) begin
                reset_flag_next = 1'b0; // see RULE_12
            end
        end
        // control two: overflow clear needs an earlier read as one
        if (wr_two) begin
            if (ovf_armed_reg && !i_wdata[TWO_OVF]) begin
                overflow_flag_next = 1'b0; // see RULE_18
            end
            ovf_armed_next = 1'b0;
            if (!i_wdata[TWO_MODE_INH]) begin
                mode_select_next = i_wdata[TWO_MODE];
            end
            if (!i_wdata[TWO_IRQ_EN_INH]) begin
                irq_enable_next = i_wdata[TWO_IRQ_EN];
            end
        end
        if (i_rd && (i_addr == ADDR_CTRL_TWO) && overflow_flag_reg) begin
            ovf_armed_next = 1'b1;
        end
        if (wr_cnt && counter_we_reg) begin
            counter_next = i_wdata; // see RULE_05
        end else if (tick && run_bit_reg && !i_module_standby) begin
            counter_next = counter_reg + 8'h01; // see RULE_09, see RULE_15
        end
        if (i_wr && (i_addr == ADDR_CLK_SEL)) begin
            clk_sel_next = i_wdata[3:0];
        end
        if (i_wr && (i_addr == ADDR_IRQ_MASK)) begin
            irq_mask_next = i_wdata[IRQ_W-1:0];
        end
        if (i_wr && (i_addr == ADDR_IRQ_STATUS)) begin
            irq_status_next = irq_status_reg & ~i_wdata[IRQ_W-1:0];
        end
        // hardware sets win over any clear in the same cycle
        if (ovf_event) begin
            overflow_flag_next = 1'b1; // see RULE_16
            irq_status_next[IRQ_OVF] = 1'b1;
        end
        if (wdrst_event) begin
            reset_flag_next = 1'b1; // see RULE_11
            irq_status_next[IRQ_WDRST] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data and outputs
    always_comb begin
        rdata_next = 8'h00;
        if (i_rd) begin
            case (i_addr)
                ADDR_CTRL_ONE: rdata_next = ONE_READ_ONES | {1'b0, counter_we_reg, 1'b0, control_we_reg,
                    1'b0, run_bit_reg, 1'b0, reset_flag_reg}; // see RULE_08
                ADDR_CTRL_TWO: rdata_next = TWO_READ_ONES | {overflow_flag_reg, 1'b0, mode_select_reg,
                    1'b0, irq_enable_reg, 3'h0};
                ADDR_COUNTER: rdata_next = counter_reg;
                ADDR_CLK_SEL: rdata_next = CLK_SEL_READ_ONES | {4'h0, clk_sel_reg};
                ADDR_IRQ_STATUS: rdata_next = {6'h00, irq_status_reg};
                ADDR_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
                default: rdata_next = 8'h00;
            endcase
        end
        wdt_reset_next = wdrst_event; // see RULE_01
        // interval request is a level while the flag stands, see RULE_02, see RULE_18
        interval_irq_next = overflow_flag_next && irq_enable_next && mode_select_next;
        irq_next = |(irq_status_next & irq_mask_next);
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            counter_we_reg <= 1'b0;
            control_we_reg <= 1'b0;
            run_bit_reg <= 1'b0;
            reset_flag_reg <= 1'b0;
            overflow_flag_reg <= 1'b0;
            ovf_armed_reg <= 1'b0;
            mode_select_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
            counter_reg <= COUNTER_RESET;
            clk_sel_reg <= CLK_SEL_RESET;
            irq_status_reg <= IRQ_RESET;
            irq_mask_reg <= IRQ_RESET;
            rdata_reg <= 8'h00;
            wdt_reset_reg <= 1'b0;
            interval_irq_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            counter_we_reg <= counter_we_next;
            control_we_reg <= control_we_next;
            run_bit_reg <= run_bit_next;
            reset_flag_reg <= reset_flag_next;
            overflow_flag_reg <= overflow_flag_next;
            ovf_armed_reg <= ovf_armed_next;
            mode_select_reg <= mode_select_next;
            irq_enable_reg <= irq_enable_next;
            counter_reg <= counter_next;
            clk_sel_reg <= clk_sel_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg <= rdata_next;
            wdt_reset_reg <= wdt_reset_next;
            interval_irq_reg <= interval_irq_next;
            irq_reg <= irq_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_wdt_reset = wdt_reset_reg;
    assign o_interval_irq = interval_irq_reg;
    assign o_irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    a_inhibit_read_ones: assert property ( // see RULE_08
        i_rd && i_addr == ADDR_CTRL_ONE |=> (o_rdata & 8'haa) == 8'haa)
        else $error("inhibit bit read as zero");
    a_counter_we_guard: assert property ( // see RULE_04
        wr_one && i_wdata[7] |=> counter_we_reg == $past(counter_we_reg))
        else $error("counter write enable changed despite inhibit");
    a_control_we_guard: assert property ( // see RULE_06
        wr_one && i_wdata[5] |=> control_we_reg == $past(control_we_reg))
        else $error("control write enable changed despite inhibit");
    a_counter_wr_block: assert property ( // see RULE_05
        wr_cnt && !counter_we_reg |=> counter_reg == $past(counter_reg) || counter_reg == $past(counter_reg) + 8'h01)
        else $error("counter took a blocked write");
    a_run_guard: assert property ( // see RULE_07
        wr_one && !control_we_reg |=> $stable(run_bit_reg))
        else $error("run bit changed without control write enable");
    a_run_set_write: assert property ( // see RULE_09
        wr_one && control_we_reg && !i_wdata[3] |=> run_bit_reg == $past(i_wdata[2]))
        else $error("run bit did not follow guarded write");
    a_halt_no_count: assert property ( // see RULE_09
        (!run_bit_reg || i_module_standby) && !wr_cnt |=> $stable(counter_reg))
        else $error("counter moved while halted");
    a_wd_reset_pulse: assert property ( // see RULE_11
        wdrst_event |=> o_wdt_reset && reset_flag_reg && overflow_flag_reg ##1 !o_wdt_reset)
        else $error("watchdog reset pulse or flag wrong");
    a_interval_no_reset: assert property ( // see RULE_02
        mode_select_reg |=> !o_wdt_reset)
        else $error("reset issued in interval mode");
    a_ovf_clear_read: assert property ( // see RULE_18
        $fell(overflow_flag_reg) |-> $past(ovf_armed_reg) && $past(wr_two))
        else $error("overflow flag cleared without prior read");
    a_irq_tracks: assert property (
        ##1 o_irq == |($past(irq_status_next) & $past(irq_mask_next)))
        else $error("interrupt output wrong");
    a_reset_flag_clear: assert property ( // see RULE_12
        wr_one && control_we_reg && !i_wdata[ONE_RST_FLAG_INH] && !i_wdata[ONE_RST_FLAG] && !wdrst_event
        |=> !reset_flag_reg)
        else $error("reset flag not cleared by guarded write");

    c_wd_reset: cover property (wdrst_event ##1 o_wdt_reset);
    c_interval_ovf: cover property (ovf_event && mode_select_reg ##2 o_interval_irq);
    c_ovf_clear: cover property (ovf_armed_reg && wr_two && !i_wdata[7]);
    c_counter_write: cover property (cnt_accept);

endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import wdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_osc_clk = 1'b0;
    logic i_module_standby = 1'b0;
    logic [7:0] o_rdata;
    logic o_wdt_reset;
    logic o_interval_irq;
    logic o_irq;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    int osc_n = 0;
    int pulses = 0;
    int t0;
    int n0;
    int p0;
    int div;
    logic [7:0] d;

    // core clock, and a free-running oscillator slow enough for the synchroniser
    always #5 i_core_clk = ~i_core_clk;
    // oscillator edges sit 2 ns off the core edges so the synchroniser never races
    initial begin
        #2;
        forever #25 i_osc_clk = ~i_osc_clk;
    end

    // cycle, oscillator edge and reset pulse bookkeeping
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (o_wdt_reset === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
    always @(posedge i_osc_clk) begin
        osc_n <= osc_n + 1;
    end

    watchdog_interval_timer_ctrl DUT (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_osc_clk(i_osc_clk),
        .i_module_standby(i_module_standby),
        .o_wdt_reset(o_wdt_reset),
        .o_interval_irq(o_interval_irq),
        .o_irq(o_irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // compare, register access and wait helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // whole-byte writes only, never read-modify-write of single bits
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    task automatic rchk(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(name, {24'h0, exp}, {24'h0, v});
    endtask

    // bounded wait for the reset pulse or the interval interrupt
    task automatic wait_sig(input bit irq, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(posedge i_core_clk);
            #1;
            if ((irq ? o_interval_irq : o_wdt_reset) === 1'b1) break;
        end
        chk("event seen", 32'h1, {31'h0, irq ? o_interval_irq : o_wdt_reset});
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // hang guard: 80k cycles, well past the ~55k that divisor sweep and oscillator runs need
    initial begin
        #800000;
        mismatches++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        rchk("ctrl one reset", ADDR_CTRL_ONE, 8'haa);
        rchk("ctrl two reset", ADDR_CTRL_TWO, 8'h57);
        rchk("counter reset", ADDR_COUNTER, 8'h00);
        rchk("clk sel reset", ADDR_CLK_SEL, 8'hff);
        rchk("status reset", ADDR_IRQ_STATUS, 8'h00);
        rchk("mask reset", ADDR_IRQ_MASK, 8'h00);
        rchk("unmapped", 3'h6, 8'h00);
        // guarded write enables
        wr(ADDR_CTRL_ONE, 8'hc0);
        rchk("counter we guarded", ADDR_CTRL_ONE, 8'haa);
        wr(ADDR_COUNTER, 8'h10);
        rchk("counter locked", ADDR_COUNTER, 8'h00);
        wr(ADDR_CTRL_ONE, 8'h40);
        rchk("counter we set", ADDR_CTRL_ONE, 8'hea);
        wr(ADDR_CTRL_ONE, 8'ha6);
        rchk("run locked", ADDR_CTRL_ONE, 8'hea);
        wr(ADDR_CTRL_ONE, 8'h9a);
        rchk("control we set", ADDR_CTRL_ONE, 8'hfa);
        // first watchdog overflow from fc at 1/64
        wr(ADDR_CLK_SEL, 8'h08);
        rchk("clk sel", ADDR_CLK_SEL, 8'hf8);
        wr(ADDR_COUNTER, 8'hfc);
        rchk("counter write", ADDR_COUNTER, 8'hfc);
        wr(ADDR_CTRL_ONE, 8'ha6);
        wait_sig(1'b0, 300);
        chk("irq masked", 32'h0, {31'h0, o_irq});
        @(posedge i_core_clk);
        #1;
        chk("reset pulse width", 32'h0, {31'h0, o_wdt_reset});
        rchk("reset flag set", ADDR_CTRL_ONE, 8'hff);
        rchk("overflow set", ADDR_CTRL_TWO, 8'hd7);
        rchk("status both", ADDR_IRQ_STATUS, 8'h03);
        rchk("counter wrapped", ADDR_COUNTER, 8'h00);
        // interrupt mask and write-one-to-clear
        wr(ADDR_IRQ_MASK, 8'h01);
        repeat (2) @(posedge i_core_clk);
        chk("irq ovf", 32'h1, {31'h0, o_irq});
        wr(ADDR_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge i_core_clk);
        chk("irq ovf cleared", 32'h0, {31'h0, o_irq});
        wr(ADDR_IRQ_MASK, 8'h02);
        repeat (2) @(posedge i_core_clk);
        chk("irq wdrst", 32'h1, {31'h0, o_irq});
        wr(ADDR_IRQ_STATUS, 8'h02);
        repeat (2) @(posedge i_core_clk);
        chk("irq wdrst cleared", 32'h0, {31'h0, o_irq});
        rchk("status cleared", ADDR_IRQ_STATUS, 8'h00);
        // period of every system divisor: wrap to wrap with counter reloaded to ff
        for (int code = 8; code < 16; code++) begin
            div = 64 << (code - 8);
            wr(ADDR_CLK_SEL, code[7:0]);
            wr(ADDR_COUNTER, 8'hff);
            wait_sig(1'b0, 2 * div + 40);
            t0 = cyc;
            wr(ADDR_COUNTER, 8'hff);
            wait_sig(1'b0, div + 40);
            chk("tick period", div, cyc - t0);
        end
        // oscillator source: 2048 oscillator edges per count
        wr(ADDR_CLK_SEL, 8'h00);
        wr(ADDR_COUNTER, 8'hff);
        wait_sig(1'b0, 21000);
        n0 = osc_n;
        wr(ADDR_COUNTER, 8'hff);
        wait_sig(1'b0, 10600);
        chk("osc edges", 32'd2048, osc_n - n0);
        // overflow flag: a write without a fresh read must not clear it
        wr(ADDR_CLK_SEL, 8'h0f);
        wr(ADDR_CTRL_TWO, 8'hd0);
        wr(ADDR_CTRL_TWO, 8'h50);
        rchk("ovf kept", ADDR_CTRL_TWO, 8'hd7);
        wr(ADDR_CTRL_TWO, 8'h50);
        rchk("ovf cleared", ADDR_CTRL_TWO, 8'h57);
        wr(ADDR_CTRL_ONE, 8'ha8);
        rchk("reset flag clear", ADDR_CTRL_ONE, 8'hfe);
        // stop the count before any low-power entry
        wr(ADDR_CTRL_ONE, 8'ha2);
        rchk("run clear", ADDR_CTRL_ONE, 8'hfa);
        wr(ADDR_CLK_SEL, 8'h08);
        rd(ADDR_COUNTER, d);
        repeat (200) @(posedge i_core_clk);
        rchk("counter halted", ADDR_COUNTER, d);
        // interval mode: interrupt, no reset pulse
        wr(ADDR_IRQ_STATUS, 8'h03);
        wr(ADDR_CTRL_TWO, 8'h28);
        rchk("interval mode", ADDR_CTRL_TWO, 8'h7f);
        wr(ADDR_COUNTER, 8'hff);
        p0 = pulses;
        wr(ADDR_CTRL_ONE, 8'ha6);
        wait_sig(1'b1, 200);
        chk("no reset pulse", p0, pulses);
        rchk("status ovf only", ADDR_IRQ_STATUS, 8'h01);
        rchk("reset flag idle", ADDR_CTRL_ONE, 8'hfe);
        chk("irq mask wdrst", 32'h0, {31'h0, o_irq});
        rchk("ovf interval", ADDR_CTRL_TWO, 8'hff);
        wr(ADDR_CTRL_TWO, 8'h28);
        repeat (2) @(posedge i_core_clk);
        chk("interval irq cleared", 32'h0, {31'h0, o_interval_irq});
        // module standby freezes the running counter
        @(posedge i_core_clk);
        i_module_standby <= 1'b1;
        rd(ADDR_COUNTER, d);
        repeat (300) @(posedge i_core_clk);
        rchk("standby halt", ADDR_COUNTER, d);
        @(posedge i_core_clk);
        i_module_standby <= 1'b0;
        // pin reset in mid-run
        @(posedge i_core_clk);
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        #1;
        chk("reset outputs", 32'h0, {29'h0, o_wdt_reset, o_interval_irq, o_irq});
        @(posedge i_core_clk);
        i_rstn <= 1'b1;
        rchk("run after reset", ADDR_CTRL_ONE, 8'haa);
        rchk("counter after reset", ADDR_COUNTER, 8'h00);
        conclude();
    end
endmodule
